/* verilog/fbp_pkg.sv */
package fbp_pkg;
  // Flash command bus codes
  localparam logic [2:0] FBP_CMD_IDLE  = 3'h0;
  localparam logic [2:0] FBP_CMD_READ  = 3'h1;
  localparam logic [2:0] FBP_CMD_WRITE = 3'h2;
  localparam logic [2:0] FBP_CMD_ROWWR = 3'h3;
  localparam logic [2:0] FBP_CMD_ERASE = 3'h4;
  localparam logic [2:0] FBP_CMD_RSV0  = 3'h5;
  localparam logic [2:0] FBP_CMD_RSV1  = 3'h6;
  localparam logic [2:0] FBP_CMD_MASS  = 3'h7;
  // Widths
  localparam int FBP_FADDR_W = 22;
  localparam int FBP_PADDR_W = 12;
  localparam int FBP_NPART   = 16;
  localparam int FBP_PART_LOG2 = 18;
  // Register byte offsets
  localparam logic [7:0] FBP_OFF_CMD    = 8'h00;
  localparam logic [7:0] FBP_OFF_ADDR   = 8'h04;
  localparam logic [7:0] FBP_OFF_WDATA  = 8'h08;
  localparam logic [7:0] FBP_OFF_RDATA  = 8'h0C;
  localparam logic [7:0] FBP_OFF_STATUS = 8'h10;
  localparam logic [7:0] FBP_OFF_ABORT  = 8'h14;
  localparam logic [7:0] FBP_OFF_PCTRL  = 8'h18;
  localparam logic [7:0] FBP_OFF_PWDATA = 8'h1C;
  localparam logic [7:0] FBP_OFF_PRDATA = 8'h20;
  // Field positions
  localparam int FBP_CMD_DOM_BIT = 3;
  localparam int FBP_ST_BUSY     = 0;
  localparam int FBP_ST_FERR     = 1;
  localparam int FBP_ST_DENY     = 2;
  localparam int FBP_ST_ABUSY    = 3;
  localparam int FBP_ST_AERR     = 4;
  localparam int FBP_PC_BANK_BIT = 12;
  localparam int FBP_PC_WR_BIT   = 16;
  localparam int FBP_PC_STRB_LSB = 20;
  localparam int FBP_PC_DOM_BIT  = 24;
  // Reset values
  localparam logic [31:0] FBP_RST_WORD = 32'h0000_0000;
  // Flash sequencer states
  typedef enum logic [2:0] {
    FBP_F_IDLE  = 3'b001,
    FBP_F_ISSUE = 3'b010,
    FBP_F_DATA  = 3'b100
  } fbp_fstate_type;
  // Register requester states
  typedef enum logic [2:0] {
    FBP_A_IDLE   = 3'b001,
    FBP_A_SETUP  = 3'b010,
    FBP_A_ACCESS = 3'b100
  } fbp_astate_type;
endpackage

/* verilog/fbp_apb_req_if.sv */
`timescale 1ns/10ps
interface fbp_apb_req_if;
  logic        start;  // One-cycle transfer request
  logic [11:0] addr;   // Target register address
  logic        write;  // Direction
  logic [3:0]  strb;   // Byte strobes
  logic [31:0] wdata;  // Write word
  logic        busy;   // Transfer under way
  logic        done;   // One-cycle completion
  logic        err;    // Completion had an error
  logic [31:0] rdata;  // Read word
  modport ctrl (output start, addr, write, strb, wdata,
                input busy, done, err, rdata);
  modport req (input start, addr, write, strb, wdata,
               output busy, done, err, rdata);
endinterface

/* verilog/fbp_apb_req.sv */
`timescale 1ns/10ps
module fbp_apb_req (
  input  wire logic  clk,
  input  wire logic  rst_n,
  fbp_apb_req_if.req ifc,
  output logic       psel_reg,
  output logic       penable_reg,
  output logic [11:0] paddr_reg,
  output logic [3:0] pstrb_reg,
  output logic       pwrite_reg,
  output logic [31:0] pwdata_reg,
  input  wire logic [31:0] prdata,
  input  wire logic  pready,
  input  wire logic  pslverr
);
  import fbp_pkg::*;
  fbp_astate_type state_reg;  // Transfer phase

  // Two-phase transfer sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= FBP_A_IDLE;
      psel_reg    <= 1'b0;
      penable_reg <= 1'b0;
      ifc.done    <= 1'b0;
      ifc.err     <= 1'b0;
    end else begin
      ifc.done <= 1'b0;
      case (state_reg)
        FBP_A_IDLE: begin
          // Select first, enable next cycle
          if (ifc.start) begin
            psel_reg  <= 1'b1;
            state_reg <= FBP_A_SETUP;
          end
        end
        FBP_A_SETUP: begin
          penable_reg <= 1'b1;
          state_reg   <= FBP_A_ACCESS;
        end
        FBP_A_ACCESS: begin
          // Stretch until target is ready
          if (pready) begin
            psel_reg    <= 1'b0;
            penable_reg <= 1'b0;
            ifc.done    <= 1'b1;
            ifc.err     <= pslverr;
            state_reg   <= FBP_A_IDLE;
          end
        end
        default: state_reg <= FBP_A_IDLE;
      endcase
    end
  end

  // Request fields and read capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      paddr_reg  <= 12'h000;
      pstrb_reg  <= 4'h0;
      pwrite_reg <= 1'b0;
      pwdata_reg <= FBP_RST_WORD;
      ifc.rdata  <= FBP_RST_WORD;
    end else if (state_reg == FBP_A_IDLE && ifc.start) begin
      paddr_reg  <= ifc.addr;
      pstrb_reg  <= ifc.write ? ifc.strb : 4'h0;
      pwrite_reg <= ifc.write;
      pwdata_reg <= ifc.wdata;
    end else if (state_reg == FBP_A_ACCESS && pready) begin
      ifc.rdata <= prdata;
    end
  end

  assign ifc.busy = (state_reg != FBP_A_IDLE);

  property p_enable_follows;
    @(posedge clk) disable iff (!rst_n)
      (psel_reg && !penable_reg) |=> (psel_reg && penable_reg);
  endproperty
  a_enable_follows: assert property (p_enable_follows)
    else $error("enable did not follow select");

  property p_wait_holds;
    @(posedge clk) disable iff (!rst_n)
      (penable_reg && !pready) |=>
        (psel_reg && penable_reg && $stable(paddr_reg)
         && $stable(pwdata_reg));
  endproperty
  a_wait_holds: assert property (p_wait_holds)
    else $error("transfer not held during wait");

  property p_err_reported;
    @(posedge clk) disable iff (!rst_n)
      (penable_reg && pready) |=> (ifc.done && ifc.err == $past(pslverr));
  endproperty
  a_err_reported: assert property (p_err_reported)
    else $error("completion status not reported");
endmodule

/* verilog/fbp_part_check.sv */
`timescale 1ns/10ps
module fbp_part_check #(
  parameter int PART_LOG2 = fbp_pkg::FBP_PART_LOG2
) (
  input  wire logic [21:0] addr,
  input  wire logic [2:0]  cmd,
  input  wire logic        domain,
  input  wire logic [15:0] owner,
  input  wire logic [15:0] rd_grant,
  input  wire logic [15:0] owner_ro,
  output logic             allow
);
  import fbp_pkg::*;
  localparam int IDXW = (PART_LOG2 < 22) ? 22 - PART_LOG2 : 1;
  logic [15:0] whole_ok;   // Per partition write right for mass erase
  logic [IDXW-1:0] raw_idx; // Partition number from address
  logic [3:0]  idx;        // Clamped partition number
  logic [IDXW+3:0] wide_idx; // Partition number, zero extended

  // Per partition rights for a mass erase, all sixteen counted
  genvar g;
  generate
    for (g = 0; g < FBP_NPART; g++) begin : g_part
      assign whole_ok[g] = (owner[g] == domain) && !owner_ro[g];
    end
  endgenerate

  // Address above the last partition falls to partition 15
  always_comb begin
    raw_idx = (PART_LOG2 < 22) ? addr[21 -: IDXW] : '0;
    // Widened so a short index still has four bits to pick from
    wide_idx = {4'h0, raw_idx};
    idx = (wide_idx > (IDXW+4)'(15)) ? 4'hF : wide_idx[3:0];
  end

  // Decision per command kind
  always_comb begin
    case (cmd)
      FBP_CMD_READ:
        allow = (owner[idx] == domain) || (rd_grant[idx] == domain);
      FBP_CMD_WRITE, FBP_CMD_ROWWR, FBP_CMD_ERASE:
        allow = (owner[idx] == domain) && !owner_ro[idx];
      FBP_CMD_MASS:
        allow = &whole_ok;
      default: allow = 1'b0;
    endcase
  end
endmodule

/* verilog/fbp_flash_ctrl.sv */
`timescale 1ns/10ps
module fbp_flash_ctrl #(
  parameter int FWDATA_WIDTH = 32,
  parameter int FRDATA_WIDTH = 32,
  parameter int PART_LOG2    = fbp_pkg::FBP_PART_LOG2
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic [21:0]      faddr,
  output logic [2:0]       fcmd,
  output logic             fabort,
  output logic [FWDATA_WIDTH-1:0] fwdata,
  input  wire logic [FRDATA_WIDTH-1:0] frdata,
  input  wire logic        fready,
  input  wire logic        fresp,
  output logic             psel_m,
  output logic             penable_m,
  output logic [11:0]      paddr_m,
  output logic [3:0]       pstrb_m,
  output logic             pwrite_m,
  output logic [31:0]      pwdata_m,
  input  wire logic [31:0] prdata_m,
  input  wire logic        pready_m,
  input  wire logic        pslverr_m,
  input  wire logic [15:0] partition_owner_select,
  input  wire logic [15:0] partition_read_grant,
  input  wire logic [15:0] partition_owner_readonly
);
  import fbp_pkg::*;

  logic [1:0]  rst_sync_reg;    // Reset release stages
  logic        rst_n;           // Released reset
  logic [15:0] own_s1_reg, own_reg; // Owner bits, two stages
  logic [15:0] rdg_s1_reg, rdg_reg; // Read grant, two stages
  logic [15:0] ro_s1_reg, ro_reg;   // Read-only, two stages
  logic [2:0]  cmd_reg;         // Software command
  logic        dom_reg;         // Software domain tag
  logic [21:0] addr_reg;        // Software flash address
  logic [31:0] wdata_reg;       // Software write word
  logic [31:0] rdata_reg;       // Last flash read word
  logic        pend_reg;        // Command waiting to launch
  logic        abort_req_reg;   // Abort asked by software
  logic        ferr_reg;        // Sticky flash error
  logic        deny_reg;        // Sticky refused command
  logic        aerr_reg;        // Sticky register path error
  logic [31:0] pctrl_reg;       // Register path control word
  logic [31:0] pwd_reg;         // Register path write word
  logic        allow;           // Partition decision
  logic        wb_req;          // New bus request this cycle
  logic        wr_cmd, wr_abort, wr_status, wr_pctrl; // Write hits
  logic        pstart;          // Register transfer launch
  logic        pfwd_ok;         // Forward allowed
  logic [31:0] rd_mux;          // Read data select
  fbp_fstate_type fstate_reg;   // Flash sequencer state
  fbp_apb_req_if apb_if ();     // Requester link

  // Two-stage reset release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Partition control inputs come from fuses, so synchronise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      own_s1_reg <= 16'h0000;
      own_reg    <= 16'h0000;
      rdg_s1_reg <= 16'h0000;
      rdg_reg    <= 16'h0000;
      ro_s1_reg  <= 16'hFFFF;
      ro_reg     <= 16'hFFFF;
    end else begin
      own_s1_reg <= partition_owner_select;
      own_reg    <= own_s1_reg;
      rdg_s1_reg <= partition_read_grant;
      rdg_reg    <= rdg_s1_reg;
      ro_s1_reg  <= partition_owner_readonly;
      ro_reg     <= ro_s1_reg;
    end
  end

  // Bus decode, answered one cycle after the request
  assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd    = wb_req && wb_we_i && wb_adr_i == FBP_OFF_CMD;
  assign wr_abort  = wb_req && wb_we_i && wb_adr_i == FBP_OFF_ABORT;
  assign wr_status = wb_req && wb_we_i && wb_adr_i == FBP_OFF_STATUS;
  assign wr_pctrl  = wb_req && wb_we_i && wb_adr_i == FBP_OFF_PCTRL;

  // Forward only primary accesses to the upper bank
  assign pfwd_ok = wb_dat_i[FBP_PC_BANK_BIT]
                   && !wb_dat_i[FBP_PC_DOM_BIT];
  assign pstart  = wr_pctrl && pfwd_ok && !apb_if.busy;

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    case (wb_adr_i)
      FBP_OFF_CMD:    rd_mux = {28'h0, dom_reg, cmd_reg};
      FBP_OFF_ADDR:   rd_mux = {10'h000, addr_reg};
      FBP_OFF_WDATA:  rd_mux = wdata_reg;
      FBP_OFF_RDATA:  rd_mux = rdata_reg;
      FBP_OFF_STATUS: rd_mux = {27'h0, aerr_reg, apb_if.busy, deny_reg,
                                ferr_reg, (fstate_reg != FBP_F_IDLE)
                                || pend_reg};
      FBP_OFF_PCTRL:  rd_mux = pctrl_reg;
      FBP_OFF_PWDATA: rd_mux = pwd_reg;
      FBP_OFF_PRDATA: rd_mux = apb_if.rdata;
      default:        rd_mux = FBP_RST_WORD;
    endcase
  end

  // Acknowledge and read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= FBP_RST_WORD;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // Software parameter registers, writes ignored while the sequencer runs (command also while pending, register path while requester busy)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg   <= FBP_CMD_IDLE;
      dom_reg   <= 1'b0;
      addr_reg  <= 22'h000000;
      wdata_reg <= FBP_RST_WORD;
      pctrl_reg <= FBP_RST_WORD;
      pwd_reg   <= FBP_RST_WORD;
    end else if (wb_req && wb_we_i) begin
      if (wr_cmd && fstate_reg == FBP_F_IDLE && !pend_reg) begin
        cmd_reg <= wb_dat_i[2:0];
        dom_reg <= wb_dat_i[FBP_CMD_DOM_BIT];
      end
      if (wb_adr_i == FBP_OFF_ADDR && fstate_reg == FBP_F_IDLE) begin
        addr_reg <= wb_dat_i[21:0];
      end
      if (wb_adr_i == FBP_OFF_WDATA && fstate_reg == FBP_F_IDLE) begin
        wdata_reg <= wb_dat_i;
      end
      if (wr_pctrl && !apb_if.busy) begin
        pctrl_reg <= wb_dat_i;
      end
      if (wb_adr_i == FBP_OFF_PWDATA && !apb_if.busy) begin
        pwd_reg <= wb_dat_i;
      end
    end
  end

  // Request fields for the register requester
  assign apb_if.start = pstart;
  assign apb_if.addr  = wb_dat_i[11:0];
  assign apb_if.write = wb_dat_i[FBP_PC_WR_BIT];
  assign apb_if.strb  = wb_dat_i[FBP_PC_STRB_LSB +: 4];
  assign apb_if.wdata = pwd_reg;

  // Partition permission check on the held command
  fbp_part_check #(.PART_LOG2(PART_LOG2)) u_part (
    .addr     (addr_reg),
    .cmd      (cmd_reg),
    .domain   (dom_reg),
    .owner    (own_reg),
    .rd_grant (rdg_reg),
    .owner_ro (ro_reg),
    .allow    (allow)
  );

  // Flash command sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fstate_reg <= FBP_F_IDLE;
      fcmd       <= FBP_CMD_IDLE;
      faddr      <= 22'h000000;
      fwdata     <= '0;
      fabort     <= 1'b0;
      rdata_reg  <= FBP_RST_WORD;
    end else begin
      case (fstate_reg)
        FBP_F_IDLE: begin
          // Launch only when the wrapper can take it
          if (pend_reg && allow && fready) begin
            fcmd       <= cmd_reg;
            faddr      <= {addr_reg[21:2], 2'b00};
            fwdata     <= FWDATA_WIDTH'(wdata_reg);
            fstate_reg <= FBP_F_ISSUE;
          end
        end
        FBP_F_ISSUE: begin
          // Hold everything until accepted
          if (fready) begin
            fcmd       <= FBP_CMD_IDLE;
            fstate_reg <= FBP_F_DATA;
          end
        end
        FBP_F_DATA: begin
          // Abort held until the wrapper is ready again
          if (abort_req_reg && !fready) begin
            fabort <= 1'b1;
          end
          if (fready) begin
            fabort     <= 1'b0;
            rdata_reg  <= 32'(frdata);
            fstate_reg <= FBP_F_IDLE;
          end
        end
        default: fstate_reg <= FBP_F_IDLE;
      endcase
    end
  end

  // Pending launch, abort request and sticky flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg      <= 1'b0;
      abort_req_reg <= 1'b0;
      ferr_reg      <= 1'b0;
      deny_reg      <= 1'b0;
      aerr_reg      <= 1'b0;
    end else begin
      if (wr_cmd && fstate_reg == FBP_F_IDLE && !pend_reg) begin
        pend_reg <= 1'b1;
      end else if (pend_reg && !allow) begin
        pend_reg <= 1'b0;
      end else if (pend_reg && fready) begin
        pend_reg <= 1'b0;
      end
      // Abort armed only while a command runs
      if (wr_abort && wb_dat_i[0] && fstate_reg != FBP_F_IDLE) begin
        abort_req_reg <= 1'b1;
      end else if (fstate_reg == FBP_F_IDLE) begin
        abort_req_reg <= 1'b0;
      end
      // Set wins over a write-one clear
      if (fresp) begin
        ferr_reg <= 1'b1;
      end else if (wr_status && wb_dat_i[FBP_ST_FERR]) begin
        ferr_reg <= 1'b0;
      end
      if (pend_reg && !allow) begin
        deny_reg <= 1'b1;
      end else if (wr_status && wb_dat_i[FBP_ST_DENY]) begin
        deny_reg <= 1'b0;
      end
      if ((apb_if.done && apb_if.err) || (wr_pctrl && !pfwd_ok)) begin
        aerr_reg <= 1'b1;
      end else if (wr_status && wb_dat_i[FBP_ST_AERR]) begin
        aerr_reg <= 1'b0;
      end
    end
  end

  // Register requester toward the wrapper
  fbp_apb_req u_apb (
    .clk         (mclk),
    .rst_n       (rst_n),
    .ifc         (apb_if),
    .psel_reg    (psel_m),
    .penable_reg (penable_m),
    .paddr_reg   (paddr_m),
    .pstrb_reg   (pstrb_m),
    .pwrite_reg  (pwrite_m),
    .pwdata_reg  (pwdata_m),
    .prdata      (prdata_m),
    .pready      (pready_m),
    .pslverr     (pslverr_m)
  );

  property p_no_reserved;
    @(posedge mclk) disable iff (!rst_n)
      fcmd != FBP_CMD_RSV0 && fcmd != FBP_CMD_RSV1;
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved command issued");

  property p_low_bits;
    @(posedge mclk) disable iff (!rst_n)
      (fcmd != FBP_CMD_IDLE) |-> faddr[1:0] == 2'b00;
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("low address bits not zero");

  property p_cmd_held;
    @(posedge mclk) disable iff (!rst_n)
      (fcmd != FBP_CMD_IDLE && !fready) |=>
        (fcmd == $past(fcmd) && $stable(faddr) && $stable(fwdata));
  endproperty
  a_cmd_held: assert property (p_cmd_held)
    else $error("command changed before ready");

  property p_abort_scope;
    @(posedge mclk) disable iff (!rst_n)
      fabort |-> (fstate_reg == FBP_F_DATA && fcmd == FBP_CMD_IDLE);
  endproperty
  a_abort_scope: assert property (p_abort_scope)
    else $error("abort outside running command");

  property p_denied;
    @(posedge mclk) disable iff (!rst_n)
      (pend_reg && !allow) |=> (fcmd == FBP_CMD_IDLE && deny_reg)[*2];
  endproperty
  a_denied: assert property (p_denied)
    else $error("refused access was issued");

  property p_mass_all;
    @(posedge mclk) disable iff (!rst_n)
      (fstate_reg == FBP_F_ISSUE && fcmd == FBP_CMD_MASS) |->
        ((own_reg == {16{dom_reg}}) && ro_reg == 16'h0000);
  endproperty
  a_mass_all: assert property (p_mass_all)
    else $error("mass erase without rights on all partitions");
endmodule

/* verif/fbp_wrap_model.sv */
`timescale 1ns/10ps
// Flash wrapper and register target seen from the controller
module fbp_wrap_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        slow,      // Stretch wait states
  input  wire logic        bad,       // Answer with errors
  input  wire logic [2:0]  fcmd,
  input  wire logic [21:0] faddr,
  input  wire logic [31:0] fwdata,
  input  wire logic        fabort,
  output logic [31:0]      frdata,
  output logic             fready,
  output logic             fresp,
  input  wire logic        psel_m,
  input  wire logic        penable_m,
  input  wire logic [11:0] paddr_m,
  input  wire logic [31:0] pwdata_m,
  output logic [31:0]      prdata_m,
  output logic             pready_m,
  output logic             pslverr_m,
  output logic [2:0]       cmd_reg,   // Last accepted command
  output logic [21:0]      addr_reg,  // Last accepted address
  output logic [31:0]      wdat_reg,  // Last accepted write word
  output logic [31:0]      pw_reg,    // Last register write word
  output logic             ab_reg     // Abort seen
);
  logic [2:0]  wait_reg;  // Flash wait states left
  logic [1:0]  err_reg;   // Error pulse cycles left
  logic [1:0]  acnt_reg;  // Register wait states so far
  logic [31:0] pword;     // Register read word
  logic [31:0] fword;     // Flash read word
  assign fword = {10'h155, addr_reg};
  assign pword = {20'h0, paddr_m} ^ 32'h5A00_0000;
  // Ready only once the wait is over
  assign fready = (wait_reg == 3'h0);
  assign fresp = (err_reg != 2'h0);
  // Stale data is inverted, never left looking valid
  assign frdata = fready ? fword : ~fword;
  assign pready_m = psel_m && penable_m && acnt_reg == {slow, 1'b0};
  assign pslverr_m = pready_m && bad;
  assign prdata_m = pready_m ? pword : ~pword;
  // Accept a command, then wait and maybe flag an error
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 3'h0;
      err_reg <= 2'h0;
      cmd_reg <= 3'h0;
      addr_reg <= 22'h0;
      wdat_reg <= 32'h0;
      ab_reg <= 1'b0;
    end else if (fready && fcmd != 3'h0) begin
      wait_reg <= slow ? 3'h5 : 3'h1;
      err_reg <= bad ? 2'h2 : 2'h0;
      cmd_reg <= fcmd;
      addr_reg <= faddr;
      wdat_reg <= fwdata;
    end else begin
      ab_reg <= ab_reg | fabort;
      if (wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
      if (err_reg != 2'h0) err_reg <= err_reg - 2'h1;
    end
  end
  // Register target wait states and write capture
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acnt_reg <= 2'h0;
      pw_reg <= 32'h0;
    end else if (psel_m && penable_m && !pready_m) begin
      acnt_reg <= acnt_reg + 2'h1;
    end else begin
      acnt_reg <= 2'h0;
      if (pready_m) pw_reg <= pwdata_m;
    end
  end
endmodule

/* verif/flash_bus_partition_ctrl_test.sv */
`timescale 1ns/10ps
// Random traffic against a reference model of the gating rules
module flash_bus_partition_ctrl_test;
  import fbp_pkg::*;
  logic        mclk = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
  logic        slow = 0, bad = 0, ack, fready, fresp, fabort;
  logic        psel, pen, pwr, pready, perr, ab_seen;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, dout, rd, r, frdata, prdata, pwdata, pw_s, wd_s;
  logic [21:0] faddr, ad_s;
  logic [2:0]  fcmd, cmd_s;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwd_m;
  logic [15:0] own = 0, rg = 0, ro = 0;
  integer      seed = 32'h8e90b086, fails = 0, compares = 0, i, c, d, a, e;
  always #25 mclk = ~mclk;
  fbp_flash_ctrl #(.PART_LOG2(16)) DUT (.mclk(mclk), .resetn(resetn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .faddr(faddr), .fcmd(fcmd), .fabort(fabort), .fwdata(pwdata),
    .frdata(frdata), .fready(fready), .fresp(fresp), .psel_m(psel),
    .penable_m(pen), .paddr_m(paddr), .pstrb_m(pstrb), .pwrite_m(pwr),
    .pwdata_m(pwd_m), .prdata_m(prdata), .pready_m(pready), .pslverr_m(perr),
    .partition_owner_select(own), .partition_read_grant(rg),
    .partition_owner_readonly(ro));
  fbp_wrap_model wrap (.mclk(mclk), .resetn(resetn), .slow(slow),
    .bad(bad), .fcmd(fcmd), .faddr(faddr), .fwdata(pwdata),
    .fabort(fabort), .frdata(frdata), .fready(fready), .fresp(fresp),
    .psel_m(psel), .penable_m(pen), .paddr_m(paddr), .pwdata_m(pwd_m),
    .prdata_m(prdata), .pready_m(pready), .pslverr_m(perr),
    .cmd_reg(cmd_s), .addr_reg(ad_s), .wdat_reg(wd_s), .pw_reg(pw_s),
    .ab_reg(ab_seen));
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, held until ack
  task wb(input logic w, input logic [7:0] a_, input logic [31:0] d_);
    @(posedge mclk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a_;
    dat <= d_;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    rd = dout;
    cyc <= 0;
    stb <= 0;
  endtask
  // Poll until neither side is busy
  task idle;
    integer m;
    m = 0;
    do begin
      wb(0, FBP_OFF_STATUS, 0);
      m++;
    end while ((rd[0] !== 1'b0 || rd[3] !== 1'b0) && m < 100);
    if (rd[0] !== 1'b0 || rd[3] !== 1'b0) fails++;
  endtask
  // Reference gating decision
  function automatic bit allow(int c, int d, int a);
    int p, k;
    p = (a >> 16) > 15 ? 15 : a >> 16;
    if (c == 7) begin
      for (k = 0; k < 16; k++) if (own[k] != d || ro[k]) return 0;
      return 1;
    end
    if (c == 1) return own[p] == d || rg[p] == d;
    return c >= 2 && c <= 4 && own[p] == d && !ro[p];
  endfunction
  // Closing verdict
  task end_sim;
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1;
    repeat (6) @(posedge mclk);
    chk(fcmd, FBP_CMD_IDLE);
    wb(0, 8'h40, 0);
    chk(rd, 0);
    // Every code, random ownership, addresses past the last partition
    for (i = 0; i < 24; i++) begin
      c = i % 8;
      d = $random(seed) & 1;
      a = $random(seed) & 32'h3FFFFC;
      own <= (i > 8 && c == 7) ? {16{d[0]}} : $random(seed);
      rg <= $random(seed);
      ro <= (i > 8 && c == 7) ? 16'h0 : $random(seed) & $random(seed);
      slow <= $random(seed);
      bad <= (i % 5 == 0);
      wb(1, FBP_OFF_STATUS, 32'h16);
      wb(1, FBP_OFF_ADDR, a);
      wb(1, FBP_OFF_WDATA, ~a);
      wb(1, FBP_OFF_CMD, {d[0], c[2:0]});
      idle;
      chk(rd[2:1], {!allow(c, d, a), allow(c, d, a) && bad});
      if (allow(c, d, a)) begin
        chk(cmd_s, c);
        if (c != 7) chk(ad_s, a);
        if (c == 2 || c == 3) chk(wd_s, ~a);
        if (c == 1) wb(0, FBP_OFF_RDATA, 0);
        if (c == 1) chk(rd, {10'h155, a[21:0]});
      end
    end
    // Abort a slow read
    own <= 0;
    ro <= 0;
    slow <= 1;
    bad <= 0;
    wb(1, FBP_OFF_ADDR, 0);
    wb(1, FBP_OFF_CMD, FBP_CMD_READ);
    wb(1, FBP_OFF_ABORT, 1);
    idle;
    chk(ab_seen, 1);
    // Forwarded register transfers, refused and errored ones
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      r[12] = (i != 1);
      r[24] = (i == 2);
      slow <= r[30];
      bad <= (i == 5);
      wb(1, FBP_OFF_STATUS, 32'h16);
      wb(1, FBP_OFF_PWDATA, ~r);
      wb(1, FBP_OFF_PCTRL, r);
      idle;
      e = !r[12] || r[24] || bad;
      chk(rd[4], e);
      if (r[12] && !r[24]) chk({pwr, pstrb, paddr}, {r[16], r[16] ? r[23:20] : 4'h0, r[11:0]});
      if (!e && r[16]) chk(pw_s, ~r);
      if (!e && !r[16]) wb(0, FBP_OFF_PRDATA, 0);
      if (!e && !r[16]) chk(rd, {20'h0, r[11:0]} ^ 32'h5A00_0000);
    end
    end_sim;
  end
endmodule
